// *** core/ipc_core.sv ***
// Design decisions made here: the APB slave port and the placing of the registers.
module ipc_core #(
  parameter int unsigned SAMPLE_CYC_P = ipc_pkg::SAMPLE_CYC
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // sensor pulses, one cycle per pulse
  input  wire ipc_pkg::ipc_pulse_t i_pulse,
  // apb slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic [31:0]           o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  // compensated increments to navigation
  output ipc_pkg::ipc_out_t     o_nav
);
  import ipc_pkg::*;

  // the tick counter is 24 bits and the pipeline needs a few idle cycles
  if (SAMPLE_CYC_P < 4 || SAMPLE_CYC_P > 16777215) begin : g_bad_cyc
    $error("sample period out of range");
  end

  // ==========================================================
  // counters and sample tick
  logic [5:0][CNT_W-1:0] cnt_q;
  logic [5:0]            pin;
  logic [23:0]           tick_cnt_q;
  logic                  tick;
  logic [31:0]           ctrl_q;

  assign pin  = {i_pulse.gyro, i_pulse.accel};
  assign tick = ctrl_q[CTRL_RUN] && (tick_cnt_q == 24'(SAMPLE_CYC_P - 1));

  always_ff @(posedge i_clk) begin
    if (i_reset || !ctrl_q[CTRL_RUN]) begin
      tick_cnt_q <= 24'h0;
    end else if (tick) begin
      tick_cnt_q <= 24'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h1;
    end
  end

  logic [5:0][CNT_W-1:0] snap_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q  <= '0;
      snap_q <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (tick) begin
          snap_q[i] <= cnt_q[i];
          cnt_q[i]  <= CNT_W'(pin[i]);
        end else begin
          cnt_q[i]  <= cnt_q[i] + CNT_W'(pin[i]);
        end
      end
    end
  end

  // ==========================================================
  // constants, operator loadable
  logic [2:0][SCL_W-1:0]   ascl_q;
  logic [2:0][CONST_W-1:0] abias_q;
  logic [2:0][GCOR_W-1:0]  gcor_q;
  logic [2:0][CONST_W-1:0] gdrf_q;
  logic [CONST_W-1:0]      unbal_q;
  logic [2:0][CONST_W-1:0] lunar_q;
  logic [2:0][CONST_W-1:0] referr_q;

  function automatic logic signed [47:0] mul_s(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
    // widen before multiplying so the product keeps its upper bits
    mul_s = 48'(a) * 48'(b);
  endfunction

  // ==========================================================
  // processing pipeline: stage 1 runs one cycle after the tick
  logic                      stg_q;
  logic [5:0][OUT_W-1:0]     res;
  logic signed [31:0]        diff [6];
  logic signed [47:0]        prod;
  logic signed [31:0]        gscl;
  logic signed [47:0]        ub;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      diff[i] = $signed({21'h0, snap_q[i]}) - $signed({21'h0, NOM_BIAS});
    end
    prod = '0;
    gscl = '0;
    for (int i = 0; i < 3; i++) begin
      // accel: q16 fps*32/0.1 units, scale per channel
      prod = mul_s(diff[i], $signed({14'h0, ascl_q[i]}));
      res[i] = OUT_W'(prod) + abias_q[i];
    end
    for (int i = 0; i < 3; i++) begin
      // gyro: 1.0 + signed correction, units 2^-32 rad
      gscl = 32'sh10000 + 32'($signed(gcor_q[i]));
      prod = mul_s(diff[i+3], gscl);
      res[i+3] = OUT_W'(prod) + gdrf_q[i];
    end
    ub = mul_s($signed(res[0]), $signed(unbal_q));
    res[3] = res[3] + OUT_W'(ub >>> 16);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stg_q <= 1'b0;
      o_nav <= '0;
    end else begin
      stg_q       <= tick;
      o_nav.valid <= stg_q;
      if (stg_q) begin
        o_nav.data <= res;
      end
    end
  end

  // ==========================================================
  // calibration sequencer
  ipc_cal_t               cal_q;
  logic [15:0]            cal_n_q;
  logic [2:0][47:0]       acc_q;
  logic                   surf_q;
  logic [1:0]             done_q;
  logic                   acal_req;
  logic                   gcal_req;
  logic                   cal_fin;
  logic [2:0][CONST_W-1:0] cal_new;

  always_comb begin
    cal_fin = stg_q && ((cal_q == IPC_ACAL && cal_n_q == 16'(ACAL_SAMPLES - 1)) ||
                        (cal_q == IPC_GCAL && cal_n_q == 16'(GCAL_SAMPLES - 1)));
    for (int i = 0; i < 3; i++) begin
      // subtract residual sum shifted right by CAL_SHIFT: negative correction opposes bias or drift
      cal_new[i] = (cal_q == IPC_ACAL) ? abias_q[i] : gdrf_q[i];
      cal_new[i] = cal_new[i] - CONST_W'($signed(acc_q[i]) >>> CAL_SHIFT);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cal_q   <= IPC_IDLE;
      cal_n_q <= 16'h0;
      acc_q   <= '0;
      surf_q  <= 1'b0;
    end else begin
      case (cal_q)
        IPC_IDLE: begin
          cal_n_q <= 16'h0;
          acc_q   <= '0;
          if (acal_req) begin
            cal_q <= IPC_ACAL;
          end else if (gcal_req) begin
            cal_q  <= IPC_GCAL;
            surf_q <= ctrl_q[CTRL_SURF];
          end
        end
        IPC_ACAL, IPC_GCAL: begin
          if (stg_q) begin
            cal_n_q <= cal_n_q + 16'h1;
            for (int i = 0; i < 3; i++) begin
              if (cal_q == IPC_ACAL) begin
                acc_q[i] <= acc_q[i] + 48'($signed(res[i]));
              end else if (surf_q) begin
                // lunar rate removed before nulling
                acc_q[i] <= acc_q[i] + 48'($signed(res[i+3] - lunar_q[i]));
              end else begin
                // residual against platform gimbal reference
                acc_q[i] <= acc_q[i] + 48'($signed(res[i+3] - referr_q[i]));
              end
            end
          end
          if (cal_fin) begin
            cal_q <= IPC_IDLE;
          end
        end
        default: cal_q <= IPC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // apb register file
  logic wr;
  logic rd;
  logic hit;
  logic [3:0] idx;
  assign wr  = i_psel && i_penable && i_pwrite;
  assign rd  = i_psel && !i_penable && !i_pwrite;
  assign idx = {2'h0, i_paddr[3:2]};
  assign acal_req = wr && i_paddr == A_CTRL && i_pwdata[CTRL_ACAL] && ctrl_q[CTRL_RUN];
  assign gcal_req = wr && i_paddr == A_CTRL && i_pwdata[CTRL_GCAL] && ctrl_q[CTRL_RUN];

  always_comb begin
    hit = (i_paddr[1:0] == 2'h0) && (i_paddr <= 8'h94);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_q   <= '0;
      ascl_q   <= {3{ASCL_RST}};
      abias_q  <= '0;
      gcor_q   <= '0;
      gdrf_q   <= '0;
      unbal_q  <= '0;
      lunar_q  <= '0;
      referr_q <= '0;
      done_q   <= '0;
    end else begin
      if (cal_fin) begin
        done_q[cal_q == IPC_GCAL] <= 1'b1;
        for (int i = 0; i < 3; i++) begin
          if (cal_q == IPC_ACAL) abias_q[i] <= cal_new[i];
          else gdrf_q[i] <= cal_new[i];
        end
      end
      if (wr && hit && idx < 4'h3) begin
        case (i_paddr[7:4])
          4'h1: ascl_q[idx]   <= i_pwdata[SCL_W-1:0];
          4'h2: if (!(cal_fin && cal_q == IPC_ACAL)) abias_q[idx] <= i_pwdata;
          4'h3: gcor_q[idx]   <= i_pwdata[GCOR_W-1:0];
          4'h4: if (!(cal_fin && cal_q == IPC_GCAL)) gdrf_q[idx] <= i_pwdata;
          4'h6: lunar_q[idx]  <= i_pwdata;
          4'h7: referr_q[idx] <= i_pwdata;
          default: ;
        endcase
      end
      if (wr && i_paddr == A_CTRL) begin
        ctrl_q <= {31'h0, i_pwdata[CTRL_RUN]} | {28'h0, i_pwdata[CTRL_SURF], 3'h0};
      end
      if (wr && i_paddr == A_UNBAL) unbal_q <= i_pwdata;
      if (wr && i_paddr == A_STAT) done_q <= done_q & ~i_pwdata[1:0] |
                                             (cal_fin ? {cal_q == IPC_GCAL, cal_q == IPC_ACAL} : 2'h0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= rd || (i_psel && !i_penable && i_pwrite);
      o_pslverr <= i_psel && !i_penable && !hit;
      if (rd) begin
        o_prdata <= 32'h0;
        // refused reads return zero
        if (hit) case (i_paddr[7:4])
          4'h0: o_prdata <= (idx == 4'h0) ? ctrl_q :
                            (idx == 4'h1) ? {28'h0, done_q, cal_q} : 32'h0;
          4'h1: if (idx < 4'h3) o_prdata <= {14'h0, ascl_q[idx]};
          4'h2: if (idx < 4'h3) o_prdata <= abias_q[idx];
          4'h3: if (idx < 4'h3) o_prdata <= {16'h0, gcor_q[idx]};
          4'h4: if (idx < 4'h3) o_prdata <= gdrf_q[idx];
          4'h5: if (idx == 4'h0) o_prdata <= unbal_q;
          4'h6: if (idx < 4'h3) o_prdata <= lunar_q[idx];
          4'h7: if (idx < 4'h3) o_prdata <= referr_q[idx];
          4'h8: o_prdata <= o_nav.data[idx[2:0] < 3'h6 ? idx[2:0] : 3'h0];
          4'h9: if (idx < 4'h2) o_prdata <= o_nav.data[3'(idx) + 3'h4];
          default: ;
        endcase
      end
    end
  end
endmodule

// *** core/ipc_pkg.sv ***
package ipc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned SAMPLE_MS       = 20;
  localparam int unsigned SAMPLE_CYC      = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned ACAL_S          = 30;
  localparam int unsigned ACAL_SAMPLES    = ACAL_S * 1000 / SAMPLE_MS;
  localparam int unsigned GCAL_S          = 300;
  localparam int unsigned GCAL_SAMPLES    = GCAL_S * 1000 / SAMPLE_MS;
  // ==========================================================
  // data path
  localparam int unsigned CNT_W           = 11;
  localparam logic [CNT_W-1:0] NOM_BIAS   = 11'h280;
  // accel scale: q2.16, nominal 1.0 = 0.1/32 fps per count; +-24 percent fits
  localparam int unsigned SCL_W           = 18;
  localparam logic [SCL_W-1:0] ASCL_RST   = 18'h10000;
  // gyro correction: q0.16 signed fraction of nominal; 0.78 percent = 511/65536
  localparam int unsigned GCOR_W          = 16;
  localparam int unsigned OUT_W           = 32;
  localparam int unsigned CONST_W         = 32;
  // ==========================================================
  // apb map
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STAT    = 8'h04;
  localparam logic [7:0] A_ASCL0   = 8'h10;
  localparam logic [7:0] A_ABIAS0  = 8'h20;
  localparam logic [7:0] A_GCOR0   = 8'h30;
  localparam logic [7:0] A_GDRF0   = 8'h40;
  localparam logic [7:0] A_UNBAL   = 8'h50;
  localparam logic [7:0] A_LUNAR0  = 8'h60;
  localparam logic [7:0] A_REFERR0 = 8'h70;
  localparam logic [7:0] A_OUT0    = 8'h80;
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_ACAL = 1;
  localparam int unsigned CTRL_GCAL = 2;
  localparam int unsigned CTRL_SURF = 3;
  localparam int unsigned CAL_SHIFT = 6;

  typedef enum logic [1:0] {IPC_IDLE, IPC_ACAL, IPC_GCAL} ipc_cal_t;

  typedef struct packed {
    logic [2:0] accel;
    logic [2:0] gyro;
  } ipc_pulse_t;

  typedef struct packed {
    logic                    valid;
    logic [5:0][OUT_W-1:0]   data;
  } ipc_out_t;
endpackage

// *** tb/ipc_sensor_model.sv ***
module ipc_sensor_model (
  // clock and burst request, accel x,y,z then gyro x,y,z
  input  wire logic                 i_clk,
  input  wire logic                 i_start,
  input  wire logic [5:0][10:0]     i_cnt,
  // pulse trains, low between pulses
  output ipc_pkg::ipc_pulse_t       o_pulse
);
  import ipc_pkg::*;
  // ====================================
  // one-cycle pulse every other cycle until each count is spent
  logic [5:0][10:0] rem_q;
  logic             phase_q;
  logic [5:0]       hi;

  always_ff @(posedge i_clk) begin
    if (i_start) begin
      rem_q <= i_cnt;
    end else if (phase_q) begin
      for (int c = 0; c < 6; c++) begin
        if (rem_q[c] != 11'h000) begin
          rem_q[c] <= rem_q[c] - 11'h001;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    phase_q <= i_start ? 1'h0 : !phase_q;
  end

  always_comb begin
    for (int c = 0; c < 6; c++) begin
      hi[c] = phase_q && (rem_q[c] != 11'h000);
    end
  end

  assign o_pulse.accel = hi[2:0];
  assign o_pulse.gyro  = hi[5:3];
endmodule

// *** tb/ipc_core_assertions.sv ***
module ipc_core_chk #(
  parameter int unsigned SAMPLE_CYC_P = ipc_pkg::SAMPLE_CYC
) (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_reset,
  // apb
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [7:0]        i_paddr,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  // navigation output
  input wire ipc_pkg::ipc_out_t o_nav
);
  import ipc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ====================================
  // cycles since the last output
  logic [17:0] gap_q;
  logic        seen_q;

  always_ff @(posedge i_clk) begin
    if (i_reset || o_nav.valid) begin
      gap_q <= 18'h00000;
    end else begin
      gap_q <= gap_q + 18'h00001;
    end
  end

  always_ff @(posedge i_clk) begin
    seen_q <= i_reset ? 1'h0 : (seen_q || o_nav.valid);
  end

  a_setup_answer: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (o_pready && i_paddr > 8'h94 |-> o_pslverr)
    else $error("unmapped access not refused");
  a_err_unaligned: assert property (o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("unaligned access not refused");
  a_err_rdzero: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == 32'h0)
    else $error("refused read not zero");
  a_nav_single: assert property (o_nav.valid |=> !o_nav.valid)
    else $error("output valid too long");
  a_nav_period: assert property (o_nav.valid && seen_q |-> gap_q == 18'(SAMPLE_CYC_P - 1))
    else $error("sample spacing wrong");
  a_reset_quiet: assert property ($fell(i_reset) |-> !o_nav.valid && !o_pready)
    else $error("outputs active after reset");

  c_nav: cover property (o_nav.valid);
  c_err: cover property (o_pslverr);
  c_write: cover property (o_pready && i_pwrite);
endmodule

bind ipc_core ipc_core_chk #(.SAMPLE_CYC_P(SAMPLE_CYC_P)) ipc_core_chk_i (.i_clk(i_clk),
  .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_nav(o_nav));

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ipc_pkg::*;
  // short sample period keeps the run brief; the model needs 2440 cycles per burst
  localparam int unsigned SMP = 4000;
  // ====================================
  // signals
  logic             clk, reset, psel, penable, pwrite, pready, pslverr, m_start, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdv;
  logic [5:0][10:0] m_cnt;
  ipc_pulse_t       pulse;
  ipc_out_t         nav;
  int               mismatches, check_count, unbal, dummy;
  int               ascl[3], abias[3], gcor[3], gdrf[3], cnt[6];
  time              t_prev;

  ipc_core #(.SAMPLE_CYC_P(SMP)) ipc_core_i (.i_clk(clk), .i_reset(reset), .i_pulse(pulse),
    .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_nav(nav));
  ipc_sensor_model ipc_sensor_model_i (.i_clk(clk), .i_start(m_start), .i_cnt(m_cnt),
    .o_pulse(pulse));

  // ====================================
  // checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n == 16) mismatches++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] f_acc(int c, int k);
    return 32'(longint'(k - int'(NOM_BIAS)) * ascl[c] + abias[c]);
  endfunction

  function automatic logic [31:0] f_gyr(int c, int k);
    longint v;
    v = longint'(k - int'(NOM_BIAS)) * (65536 + gcor[c]) + gdrf[c];
    if (c == 0) v += (longint'(int'(f_acc(0, cnt[0]))) * unbal) >>> 16;
    return 32'(v);
  endfunction

  // waits for one output and compares it with the counts sent in its interval
  task automatic interval();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (nav.valid !== 1'h1 && n < 4500);
    if (n == 4500) mismatches++;
    if (t_prev != 0) check(32'(($time - t_prev) / 100), 32'(SMP));
    t_prev = $time;
    for (int c = 0; c < 3; c++) begin
      check(nav.data[c], f_acc(c, cnt[c]));
      check(nav.data[c + 3], f_gyr(c, cnt[c + 3]));
    end
    apb(1'h0, A_OUT0 + 8'h0c, 32'h0);
    check(rdv, f_gyr(0, cnt[3]));
  endtask

  task automatic send();
    for (int c = 0; c < 6; c++) m_cnt[c] <= 11'(cnt[c]);
    m_start <= 1'h1;
    @(posedge clk);
    m_start <= 1'h0;
  endtask

  // ====================================
  // clock, watchdog and sequence
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial begin
    {reset, m_start} = 2'h3;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    m_cnt = '0;
    {mismatches, check_count, unbal, t_prev} = '0;
    cnt = '{default: 0};
    dummy = $urandom(76781);
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    m_start <= 1'h0;
    @(posedge clk);
    apb(1'h1, 8'h11, 32'h0);
    check({31'h0, err}, 32'h1);
    foreach (cnt[i]) begin
      apb(1'h0, (i < 3) ? A_ASCL0 + 8'(4 * i) : 8'(8'h95 + 8'(8 * i)), 32'h0);
      check(rdv, (i < 3) ? 32'(ASCL_RST) : 32'h0);
      check({31'h0, err}, (i < 3) ? 32'h0 : 32'h1);
    end
    for (int c = 0; c < 3; c++) begin
      ascl[c] = 65536 + int'($urandom_range(31456)) - 15728;
      abias[c] = int'($urandom_range(131072)) - 65536;
      gcor[c] = int'($urandom_range(1022)) - 511;
      gdrf[c] = int'($urandom_range(131072)) - 65536;
      apb(1'h1, A_ASCL0 + 8'(4 * c), 32'(ascl[c]));
      apb(1'h1, A_ABIAS0 + 8'(4 * c), 32'(abias[c]));
      apb(1'h1, A_GCOR0 + 8'(4 * c), 32'(gcor[c]));
      apb(1'h1, A_GDRF0 + 8'(4 * c), 32'(gdrf[c]));
      apb(1'h0, A_GDRF0 + 8'(4 * c), 32'h0);
      check(rdv, 32'(gdrf[c]));
    end
    unbal = int'($urandom_range(65536)) - 32768;
    apb(1'h1, A_UNBAL, 32'(unbal));
    apb(1'h1, A_CTRL, 32'h2);
    apb(1'h0, A_STAT, 32'h0);
    check(rdv & 32'h3, 32'h0);
    apb(1'h1, A_CTRL, 32'h1);
    interval();
    foreach (cnt[i]) cnt[i] = 60 + int'($urandom_range(1160));
    cnt[1] = 640;
    cnt[5] = 1220;
    send();
    interval();
    cnt = '{default: 60};
    send();
    interval();
    apb(1'h1, A_CTRL, 32'h3);
    apb(1'h0, A_STAT, 32'h0);
    check(rdv & 32'h3, 32'h1);
    apb(1'h1, A_CTRL, 32'h5);
    apb(1'h0, A_STAT, 32'h0);
    check(rdv & 32'h3, 32'h1);
    final_report();
  end
endmodule
